// ---- core/i2cs_pkg.sv ----
// Constants shared by the two-wire configuration port and its buffer.
// Assumes a single 250 MHz clock domain and synchronous reset.
package i2cs_pkg;

	// Clock period in nanoseconds
	localparam int CLK_PERIOD_NS = 4;

	// Device-type identifiers
	localparam logic [3:0] ID_MEM     = 4'hA;
	localparam logic [3:0] ID_MEM_ALT = 4'hB;
	localparam logic [3:0] ID_CMD     = 4'h9;

	// Pointer of the write-protect register under the command identifier
	localparam logic [7:0] WP_PTR    = 8'h87;
	// Unlock code for either nibble of the write-protect register
	localparam logic [3:0] WP_UNLOCK = 4'h5;
	// Write-protect reset value: both nibbles locked
	localparam logic [7:0] WP_RESET  = 8'h00;
	// Nibble positions inside the write-protect register
	localparam int WP_MEM_LSB = 4;
	localparam int WP_CFG_LSB = 0;

	// Pointer bit that, when clear, marks an ADC channel select
	localparam int ADC_FLAG_BIT = 7;
	// Channel field of an ADC pointer byte
	localparam int ADC_CH_MSB = 6;
	localparam int ADC_CH_LSB = 3;

	// Page size of memory and configuration writes, as a low-bit count
	localparam int PAGE_BITS = 4;

	// ADC conversion time and its cycle count (longest time: round down)
	localparam int ADC_CONV_NS  = 70000;
	localparam int ADC_CONV_CYC = ADC_CONV_NS / CLK_PERIOD_NS;

	// Write targets
	localparam logic [1:0] TGT_MEM = 2'h0;
	localparam logic [1:0] TGT_CFG = 2'h1;
	localparam logic [1:0] TGT_CMD = 2'h2;

	// Width of one buffered write: target, pointer, data
	localparam int WR_WIDTH = 18;

	// Bit-level protocol states
	typedef enum logic [8:0] {
		ST_IDLE   = 9'h001,
		ST_ADDR   = 9'h002,
		ST_AACK   = 9'h004,
		ST_PTR    = 9'h008,
		ST_PACK   = 9'h010,
		ST_WDATA  = 9'h020,
		ST_WACK   = 9'h040,
		ST_RDATA  = 9'h080,
		ST_RACK   = 9'h100
	} i2cs_state_t;

endpackage : i2cs_pkg

// ---- core/i2cs_pair_buffer.sv ----
// Two-entry buffer with valid and ready on both sides.
// Assumes source and sink sit on the same clock as the buffer.
`timescale 1ns/1ps
module i2cs_pair_buffer
#(
	parameter int WIDTH = 18
)
(
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             srst,
	// Filling side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// Draining side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);

	////////////////////////////////////////////////////////////////////////
	logic [WIDTH-1:0] head_q;      // Oldest entry, drives the output
	logic             headValid_q; // Head holds a word
	logic [WIDTH-1:0] tail_q;      // Second entry
	logic             tailValid_q; // Tail holds a word
	logic             push;        // Word taken in
	logic             pop;         // Word handed out

	// Full only when the tail is taken, so ready never depends on the sink
	assign inReady  = !tailValid_q;
	assign outValid = headValid_q;
	assign outData  = head_q;
	assign push     = inValid && !tailValid_q;
	assign pop      = headValid_q && outReady;

	////////////////////////////////////////////////////////////////////////
	// Entry movement
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			headValid_q <= 1'b0;
			tailValid_q <= 1'b0;
			head_q      <= '0;
			tail_q      <= '0;
		end
		else if (pop)
		begin
			// Tail moves up; a push cannot coincide with a full tail
			if (tailValid_q)
			begin
				head_q      <= tail_q;
				tailValid_q <= 1'b0;
			end
			else
			begin
				head_q      <= inData;
				headValid_q <= push;
			end
		end
		else if (push)
		begin
			if (!headValid_q)
			begin
				head_q      <= inData;
				headValid_q <= 1'b1;
			end
			else
			begin
				tail_q      <= inData;
				tailValid_q <= 1'b1;
			end
		end
	end

endmodule : i2cs_pair_buffer

// ---- core/i2cs_config_port.sv ----
// Two-wire slave port reaching memory, configuration, command registers
// and the ADC readout. SCL and SDA are sampled by the 250 MHz clock;
// writes leave through a two-entry buffer, reads fetch rdData by pointer.
`timescale 1ns/1ps
module i2cs_config_port
#(
	parameter int ADC_CONV_CYC = i2cs_pkg::ADC_CONV_CYC
)
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// Serial pins; SDA is open drain, enable low while driving
	input  wire logic        sclIn,
	input  wire logic        sdaIn,
	output logic             sdaOut,
	output logic             sdaOeN,
	input  wire logic        addr_strap_pin,
	// Stored configuration
	input  wire logic        altTypeSel,
	input  wire logic [1:0]  busAddrCfg,
	input  wire logic        ba2FromStrap,
	// Write stream
	output logic             wrValid,
	input  wire logic        wrReady,
	output logic [1:0]       wrTarget,
	output logic [7:0]       wrAddr,
	output logic [7:0]       wrData,
	// Nonvolatile commit
	output logic             commitStart,
	output logic [1:0]       commitTarget,
	// Read fetch
	output logic [1:0]       rdTarget,
	output logic [7:0]       rdAddr,
	input  wire logic [7:0]  rdData,
	// ADC conversion
	output logic             adcStart,
	output logic [3:0]       adcChannel,
	// Supervisor controls
	output logic             monitorSuspend,
	output logic             active_output_trim
);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge detection
	logic [1:0] sclSync_q;   // Two-flop chain for SCL
	logic [1:0] sdaSync_q;   // Two-flop chain for SDA
	logic [1:0] strapSync_q; // Two-flop chain for the strap
	logic       sclLast_q;   // Previous synchronised SCL
	logic       sdaLast_q;   // Previous synchronised SDA
	logic       sclRise;
	logic       sclFall;
	logic       startCond;
	logic       stopCond;

	// Only the second flop of each chain is read by logic
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			sclSync_q   <= 2'h3;
			sdaSync_q   <= 2'h3;
			strapSync_q <= 2'h0;
			sclLast_q   <= 1'b1;
			sdaLast_q   <= 1'b1;
		end
		else
		begin
			sclSync_q   <= {sclSync_q[0], sclIn};
			sdaSync_q   <= {sdaSync_q[0], sdaIn};
			strapSync_q <= {strapSync_q[0], addr_strap_pin};
			sclLast_q   <= sclSync_q[1];
			sdaLast_q   <= sdaSync_q[1];
		end
	end

	assign sclRise   = sclSync_q[1] && !sclLast_q;
	assign sclFall   = !sclSync_q[1] && sclLast_q;
	assign startCond = sclSync_q[1] && sclLast_q &&
		sdaLast_q && !sdaSync_q[1];
	assign stopCond  = sclSync_q[1] && sclLast_q &&
		!sdaLast_q && sdaSync_q[1];

	////////////////////////////////////////////////////////////////////////
	// Protocol state and byte registers
	i2cs_pkg::i2cs_state_t state_q;
	logic [3:0] bitCnt_q;     // Bits seen in the current byte
	logic [7:0] rxShift_q;    // Received byte
	logic [7:0] txShift_q;    // Byte being sent
	logic       hostAck_q;    // Host acknowledged the last read byte
	logic [1:0] tgt_q;        // Target chosen by the address byte
	logic [7:0] ptr_q;        // Register or memory pointer
	logic [7:0] wp_q;         // Write-protect register
	logic       commitPend_q; // Page data awaits commit at stop
	logic       adcBusy;      // Conversion in progress
	logic [$clog2(ADC_CONV_CYC+1)-1:0] adcCnt_q; // Conversion timer

	// Address byte decode
	logic       typeMem;
	logic       typeCmd;
	logic       ba2Want;
	logic       addrMatch;
	logic       wrAllowed;
	logic       pushReq;
	logic       bufReady;
	logic [7:0] ptrPageInc;

	assign ba2Want = ba2FromStrap ? strapSync_q[1] : 1'b0;
	assign typeMem = rxShift_q[7:4] == (altTypeSel ?
		i2cs_pkg::ID_MEM_ALT : i2cs_pkg::ID_MEM);
	assign typeCmd = rxShift_q[7:4] == i2cs_pkg::ID_CMD;
	// Memory ignores BA0 in matching since it picks the target
	assign addrMatch = !adcBusy && rxShift_q[3] == ba2Want &&
		rxShift_q[2] == busAddrCfg[1] &&
		(typeMem || (typeCmd && rxShift_q[1] == busAddrCfg[0]));

	// Nibble unlock per target; command writes are always allowed
	assign wrAllowed = (tgt_q == i2cs_pkg::TGT_CMD) ||
		(tgt_q == i2cs_pkg::TGT_MEM &&
		 wp_q[i2cs_pkg::WP_MEM_LSB +: 4] == i2cs_pkg::WP_UNLOCK) ||
		(tgt_q == i2cs_pkg::TGT_CFG &&
		 wp_q[i2cs_pkg::WP_CFG_LSB +: 4] == i2cs_pkg::WP_UNLOCK);

	// Page-local increment keeps the page bits fixed
	assign ptrPageInc = {ptr_q[7:i2cs_pkg::PAGE_BITS],
		ptr_q[i2cs_pkg::PAGE_BITS-1:0] + 4'h1};

	// Data byte complete, headed for the buffer
	assign pushReq = sclFall && state_q == i2cs_pkg::ST_WDATA &&
		bitCnt_q == 4'h8 && wrAllowed &&
		!(tgt_q == i2cs_pkg::TGT_CMD && ptr_q == i2cs_pkg::WP_PTR);

	////////////////////////////////////////////////////////////////////////
	// Bit engine: sample on rise, drive on fall
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state_q   <= i2cs_pkg::ST_IDLE;
			bitCnt_q  <= 4'h0;
			rxShift_q <= 8'h00;
			txShift_q <= 8'h00;
			hostAck_q <= 1'b0;
			sdaOeN    <= 1'b1;
			tgt_q     <= i2cs_pkg::TGT_MEM;
		end
		else if (startCond)
		begin
			// Start or repeated start: pointer survives for reads
			state_q  <= i2cs_pkg::ST_ADDR;
			bitCnt_q <= 4'h0;
			sdaOeN   <= 1'b1;
		end
		else if (stopCond)
		begin
			state_q <= i2cs_pkg::ST_IDLE;
			sdaOeN  <= 1'b1;
		end
		else if (sclRise)
		begin
			// Receive side samples here only
			unique case (state_q)
				i2cs_pkg::ST_ADDR, i2cs_pkg::ST_PTR, i2cs_pkg::ST_WDATA:
				begin
					rxShift_q <= {rxShift_q[6:0], sdaSync_q[1]};
					bitCnt_q  <= bitCnt_q + 4'h1;
				end
				i2cs_pkg::ST_RDATA:
				begin
					bitCnt_q <= bitCnt_q + 4'h1;
				end
				i2cs_pkg::ST_RACK:
				begin
					hostAck_q <= !sdaSync_q[1];
				end
				default:
				begin
					hostAck_q <= hostAck_q;
				end
			endcase
		end
		else if (sclFall)
		begin
			// SDA only moves while SCL is low
			unique case (state_q)
				i2cs_pkg::ST_ADDR:
				begin
					if (bitCnt_q == 4'h8)
					begin
						// Type, bus select, direction
						if (addrMatch)
						begin
							state_q <= i2cs_pkg::ST_AACK;
							sdaOeN  <= 1'b0;
							tgt_q   <= typeCmd ? i2cs_pkg::TGT_CMD :
								(rxShift_q[1] ? i2cs_pkg::TGT_CFG :
								 i2cs_pkg::TGT_MEM);
						end
						else
						begin
							state_q <= i2cs_pkg::ST_IDLE;
						end
					end
				end
				i2cs_pkg::ST_AACK:
				begin
					bitCnt_q <= 4'h0;
					if (rxShift_q[0])
					begin
						// Read: first byte comes from the set pointer
						state_q   <= i2cs_pkg::ST_RDATA;
						txShift_q <= {rdData[6:0], 1'b0};
						sdaOeN    <= rdData[7];
					end
					else
					begin
						state_q <= i2cs_pkg::ST_PTR;
						sdaOeN  <= 1'b1;
					end
				end
				i2cs_pkg::ST_PTR:
				begin
					if (bitCnt_q == 4'h8)
					begin
						state_q <= i2cs_pkg::ST_PACK;
						sdaOeN  <= 1'b0;
					end
				end
				i2cs_pkg::ST_PACK, i2cs_pkg::ST_WACK:
				begin
					state_q  <= i2cs_pkg::ST_WDATA;
					bitCnt_q <= 4'h0;
					sdaOeN   <= 1'b1;
				end
				i2cs_pkg::ST_WDATA:
				begin
					if (bitCnt_q == 4'h8)
					begin
						// A full buffer cannot stretch SCL, so refuse
						state_q <= i2cs_pkg::ST_WACK;
						sdaOeN  <= !(bufReady || !pushReq);
					end
				end
				i2cs_pkg::ST_RDATA:
				begin
					if (bitCnt_q == 4'h8)
					begin
						// Release for the host acknowledge
						state_q <= i2cs_pkg::ST_RACK;
						sdaOeN  <= 1'b1;
					end
					else
					begin
						txShift_q <= {txShift_q[6:0], 1'b0};
						sdaOeN    <= txShift_q[7];
					end
				end
				i2cs_pkg::ST_RACK:
				begin
					bitCnt_q <= 4'h0;
					if (hostAck_q)
					begin
						state_q   <= i2cs_pkg::ST_RDATA;
						txShift_q <= {rdData[6:0], 1'b0};
						sdaOeN    <= rdData[7];
					end
					else
					begin
						state_q <= i2cs_pkg::ST_IDLE;
						sdaOeN  <= 1'b1;
					end
				end
				default:
				begin
					sdaOeN <= 1'b1;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pointer: set by the pointer byte, advanced per byte
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ptr_q <= 8'h00;
		end
		else if (sclFall && state_q == i2cs_pkg::ST_PTR &&
			bitCnt_q == 4'h8)
		begin
			ptr_q <= rxShift_q;
		end
		else if (sclFall && state_q == i2cs_pkg::ST_WDATA &&
			bitCnt_q == 4'h8 && tgt_q != i2cs_pkg::TGT_CMD)
		begin
			ptr_q <= ptrPageInc;
		end
		else if (sclFall && bitCnt_q == 4'h8 &&
			(state_q == i2cs_pkg::ST_RDATA ||
			 (state_q == i2cs_pkg::ST_WDATA &&
			  tgt_q == i2cs_pkg::TGT_CMD)))
		begin
			// Early advance gives the fetch a whole SCL period to settle
			ptr_q <= ptr_q + 8'h01;
		end
	end

	// Fetch address outputs
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			rdAddr   <= 8'h00;
			rdTarget <= i2cs_pkg::TGT_MEM;
		end
		else
		begin
			rdAddr   <= ptr_q;
			rdTarget <= tgt_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Write-protect register, volatile, locked from reset
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			wp_q <= i2cs_pkg::WP_RESET;
		end
		else if (sclFall && state_q == i2cs_pkg::ST_WDATA &&
			bitCnt_q == 4'h8 && tgt_q == i2cs_pkg::TGT_CMD &&
			ptr_q == i2cs_pkg::WP_PTR)
		begin
			wp_q <= rxShift_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Commit at stop once page data was accepted
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			commitPend_q <= 1'b0;
			commitStart  <= 1'b0;
			commitTarget <= i2cs_pkg::TGT_MEM;
		end
		else
		begin
			commitStart <= 1'b0;
			if (stopCond)
			begin
				commitStart  <= commitPend_q;
				commitPend_q <= 1'b0;
			end
			else if (pushReq && bufReady && tgt_q != i2cs_pkg::TGT_CMD)
			begin
				commitPend_q <= 1'b1;
				commitTarget <= tgt_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// ADC conversion timer; blocks address acks while it runs
	assign adcBusy = adcCnt_q != '0;

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			adcCnt_q   <= '0;
			adcStart   <= 1'b0;
			adcChannel <= 4'h0;
		end
		else
		begin
			adcStart <= 1'b0;
			if (sclFall && state_q == i2cs_pkg::ST_PACK &&
				tgt_q == i2cs_pkg::TGT_CMD &&
				!ptr_q[i2cs_pkg::ADC_FLAG_BIT])
			begin
				adcStart   <= 1'b1;
				adcChannel <= ptr_q[i2cs_pkg::ADC_CH_MSB:
					i2cs_pkg::ADC_CH_LSB];
				adcCnt_q   <= ($clog2(ADC_CONV_CYC+1))'(ADC_CONV_CYC);
			end
			else if (adcBusy)
			begin
				adcCnt_q <= adcCnt_q - 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Monitoring suspension; trim loop is never paused
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			monitorSuspend     <= 1'b0;
			active_output_trim <= 1'b0;
			sdaOut             <= 1'b0;
		end
		else
		begin
			active_output_trim <= 1'b1;
			sdaOut             <= 1'b0;
			if (stopCond)
			begin
				monitorSuspend <= 1'b0;
			end
			else if (sclFall && state_q == i2cs_pkg::ST_ADDR &&
				bitCnt_q == 4'h8 && addrMatch)
			begin
				monitorSuspend <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Write stream buffer
	i2cs_pair_buffer
	#(
		.WIDTH (i2cs_pkg::WR_WIDTH)
	)
	u_wrBuf
	(
		.clk      (clk),
		.srst     (srst),
		.inValid  (pushReq),
		.inReady  (bufReady),
		.inData   ({tgt_q, ptr_q, rxShift_q}),
		.outValid (wrValid),
		.outReady (wrReady),
		.outData  ({wrTarget, wrAddr, wrData})
	);

endmodule : i2cs_config_port

// ---- verification/i2cs_config_port_checker.sv ----
// Port-level checker for the two-wire configuration port.
// Assumes one clock domain; bound to the port from the bench top.
`timescale 1ns/1ps
module i2cs_config_port_checker
#(
	parameter int ADC_CONV_CYC = 17500
)
(
	// Clock and reset
	input wire logic       clk,
	input wire logic       srst,
	// Serial pins
	input wire logic       sclIn,
	input wire logic       sdaOut,
	input wire logic       sdaOeN,
	// Write stream
	input wire logic       wrValid,
	input wire logic       wrReady,
	input wire logic [1:0] wrTarget,
	input wire logic [7:0] wrAddr,
	input wire logic [7:0] wrData,
	// Supervisor side
	input wire logic       commitStart,
	input wire logic [1:0] commitTarget,
	input wire logic       adcStart,
	input wire logic       monitorSuspend,
	input wire logic       active_output_trim
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	////////////////////////////////////////////////////////////////////////
	// Conversion cycles left; two short so pulse latency cannot trip it
	int adcLeft_q;

	always_ff @(posedge clk)
	begin
		if (srst)
			adcLeft_q <= 0;
		else if (adcStart)
			adcLeft_q <= ADC_CONV_CYC - 2;
		else if (adcLeft_q != 0)
			adcLeft_q <= adcLeft_q - 1;
	end

	////////////////////////////////////////////////////////////////////////
	AST_TRIM_RUNS: assert property ($past(!srst) |-> active_output_trim)
		else $error("trim loop not running");
	AST_COMMIT_ONE: assert property (commitStart |=> !commitStart)
		else $error("commit pulse too long");
	AST_COMMIT_FRAME: assert property (commitStart |->
		$past(monitorSuspend) || $past(monitorSuspend, 3))
		else $error("commit outside a suspended frame");
	AST_COMMIT_NOT_CMD: assert property (commitStart |->
		commitTarget != i2cs_pkg::TGT_CMD)
		else $error("commit for command target");
	AST_ADC_PULSE: assert property (adcStart |-> monitorSuspend ##1 !adcStart)
		else $error("conversion pulse malformed");
	// Data acks that hand a word on stay legal; address acks do not
	AST_ADC_NO_ACK: assert property (adcLeft_q != 0 && $fell(sdaOeN) |->
		wrValid)
		else $error("acknowledge during conversion");
	AST_ACK_SUSPENDS: assert property ($fell(sdaOeN) |-> ##[0:8] monitorSuspend)
		else $error("drive without suspension");
	AST_SDA_SCL_LOW: assert property ($changed(sdaOeN) |-> !sclIn)
		else $error("data changed while clock high");
	AST_WR_HOLD: assert property (wrValid && !wrReady |=> wrValid &&
		$stable({wrTarget, wrAddr, wrData}))
		else $error("stalled write entry changed");
	AST_OPEN_DRAIN: assert property (!sdaOeN |-> sdaOut == 1'b0)
		else $error("data pin driven high");
endmodule : i2cs_config_port_checker

// ---- verification/i2cs_host_model.sv ----
// Behavioural host bus master for the two-wire configuration port.
// Assumes an SDA pull-up resolved by the bench from both pull-downs.
`timescale 1ns/1ps
module i2cs_host_model
(
	// Wire level as resolved by the bench
	input  wire logic sdaWire,
	// Host-driven lines
	output logic      sclLine,
	output logic      hostPullN
);
	// Idle: clock stands high, data released to the pull-up
	initial
	begin
		sclLine = 1'b1;
		hostPullN = 1'b1;
	end

	// Start or repeated start: data falls while clock high
	task automatic frameStart;
		#20 hostPullN = 1'b1;
		#40 sclLine = 1'b1;
		#40 hostPullN = 1'b0;
		#40 sclLine = 1'b0;
	endtask : frameStart

	// Stop: data rises while clock high, clock then stands still
	task automatic frameStop;
		#20 hostPullN = 1'b0;
		#40 sclLine = 1'b1;
		#40 hostPullN = 1'b1;
		#40;
	endtask : frameStop

	// One 160 ns clock; data set well after the fall to avoid a false stop
	task automatic clockBit(input logic drive, output logic seen);
		#20 hostPullN = drive;
		#60 sclLine = 1'b1;
		#40 seen = sdaWire;
		#40 sclLine = 1'b0;
	endtask : clockBit

	// Byte out, top bit first, then the device's acknowledge slot
	task automatic sendByte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			clockBit(b[i], s);
		clockBit(1'b1, s);
		ack = !s;
	endtask : sendByte

	// Byte in; acknowledge asks for more, release ends the read
	task automatic readByte(input logic more, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--)
			clockBit(1'b1, b[i]);
		clockBit(!more, s);
	endtask : readByte
endmodule : i2cs_host_model

// ---- verification/i2cs_config_port_tb_top.sv ----
// Bench for the two-wire configuration port driven by a host model.
// Assumes the package, buffer, port and host model compile first.
`timescale 1ns/1ps
module i2cs_config_port_tb_top;
	logic        clk;
	logic        srst;
	logic        sdaOut;
	logic        sdaOeN;
	logic        sclLine;
	logic        hostPullN;
	wire         sdaWire;
	logic        strapPin;
	logic        altTypeSel;
	logic [1:0]  busAddrCfg;
	logic        ba2FromStrap;
	logic        wrValid;
	logic        wrReady;
	logic [1:0]  wrTarget;
	logic [7:0]  wrAddr;
	logic [7:0]  wrData;
	logic        commitStart;
	logic [1:0]  commitTarget;
	logic [1:0]  rdTarget;
	logic [7:0]  rdAddr;
	logic [7:0]  rdData;
	logic        adcStart;
	logic [3:0]  adcChannel;
	logic        monitorSuspend;
	logic        trimOn;
	int          num_errors;
	int          compares;
	int          numCommits;
	logic [17:0] wrSeen[$];

	// Pull-up wire: low while either party pulls
	assign sdaWire = sdaOeN & hostPullN;
	// Fetch source: a pattern keyed to target and pointer
	assign rdData = rdAddr ^ {rdTarget, 6'h2A};

	// Short conversion keeps the run brief, yet the first polls are refused
	i2cs_config_port #(.ADC_CONV_CYC(1000)) dut_u (.clk(clk), .srst(srst),
		.sclIn(sclLine), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
		.addr_strap_pin(strapPin), .altTypeSel(altTypeSel),
		.busAddrCfg(busAddrCfg), .ba2FromStrap(ba2FromStrap),
		.wrValid(wrValid), .wrReady(wrReady), .wrTarget(wrTarget),
		.wrAddr(wrAddr), .wrData(wrData), .commitStart(commitStart),
		.commitTarget(commitTarget), .rdTarget(rdTarget), .rdAddr(rdAddr),
		.rdData(rdData), .adcStart(adcStart), .adcChannel(adcChannel),
		.monitorSuspend(monitorSuspend), .active_output_trim(trimOn));
	i2cs_host_model host_u (.sdaWire(sdaWire), .sclLine(sclLine),
		.hostPullN(hostPullN));

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Collect taken write entries and commit pulses
	always @(posedge clk)
	begin
		if (!srst && wrValid && wrReady)
			wrSeen.push_back({wrTarget, wrAddr, wrData});
		if (!srst && commitStart)
			numCommits++;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [17:0] seen,
		input logic [17:0] exp);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic tx(input logic [7:0] b, input logic expAck);
		logic ack;
		host_u.sendByte(b, ack);
		check("acknowledge", 18'(ack), 18'(expAck));
	endtask : tx

	task automatic end_sim;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim

	////////////////////////////////////////////////////////////////////////
	// Address decode under three configs: {alt, ba2 from strap}, byte, ack
	task automatic testAddress;
		logic [10:0] tbl [12];
		tbl = '{{2'h1, 8'hAC, 1'h1}, {2'h1, 8'hAE, 1'h1}, {2'h1, 8'hA4, 1'h0},
			{2'h1, 8'hA8, 1'h0}, {2'h1, 8'h9C, 1'h1}, {2'h1, 8'h9E, 1'h0},
			{2'h1, 8'hBC, 1'h0}, {2'h1, 8'h5C, 1'h0}, {2'h3, 8'hBC, 1'h1},
			{2'h3, 8'hAC, 1'h0}, {2'h0, 8'hAC, 1'h0}, {2'h0, 8'hA4, 1'h1}};
		foreach (tbl[i])
		begin
			@(negedge clk);
			{altTypeSel, ba2FromStrap} = tbl[i][10:9];
			host_u.frameStart();
			tx(tbl[i][8:1], tbl[i][0]);
			check("suspend", 18'(monitorSuspend), 18'(tbl[i][0]));
			host_u.frameStop();
			repeat (8) @(negedge clk);
			check("resume", 18'(monitorSuspend), 18'h0);
		end
	endtask : testAddress

	// Locked write, unlock, then a page write that wraps in its page
	task automatic testWrite;
		int n0;
		logic [3:0] lo;
		host_u.frameStart();
		tx(8'hA6, 1'b1);
		tx(8'h0E, 1'b1);
		tx(8'h11, 1'b1);
		host_u.frameStop();
		host_u.frameStart();
		tx(8'h94, 1'b1);
		tx(i2cs_pkg::WP_PTR, 1'b1);
		tx({i2cs_pkg::WP_UNLOCK, i2cs_pkg::WP_UNLOCK}, 1'b1);
		host_u.frameStop();
		repeat (8) @(negedge clk);
		check("locked stream", 18'(wrSeen.size()), 18'h0);
		n0 = numCommits;
		host_u.frameStart();
		tx(8'hA6, 1'b1);
		tx(8'h0E, 1'b1);
		for (int i = 0; i < 3; i++)
			tx(8'h30 + 8'(i), 1'b1);
		host_u.frameStop();
		repeat (8) @(negedge clk);
		check("commits", 18'(numCommits - n0), 18'h1);
		check("commit target", 18'(commitTarget), 18'h1);
		check("stream size", 18'(wrSeen.size()), 18'h3);
		for (int i = 0; i < 3; i++)
		begin
			lo = 4'hE + 4'(i);
			check("page entry", wrSeen.pop_front(),
				{i2cs_pkg::TGT_CFG, 4'h0, lo, 8'h30 + 8'(i)});
		end
	endtask : testWrite

	// Dummy write, repeated start, three reads with the last refused
	task automatic testRead;
		logic [7:0] b;
		host_u.frameStart();
		tx(8'hA4, 1'b1);
		tx(8'h40, 1'b1);
		host_u.frameStart();
		tx(8'hA5, 1'b1);
		for (int i = 0; i < 3; i++)
		begin
			host_u.readByte(i < 2, b);
			check("read byte", 18'(b), 18'((8'h40 + 8'(i)) ^ 8'h2A));
		end
		host_u.frameStop();
		repeat (8) @(negedge clk);
		check("released", 18'(sdaOeN), 18'h1);
	endtask : testRead

	// Receiver stalls: two entries held, third byte refused, no commit
	task automatic testStall;
		int n0;
		@(negedge clk);
		wrReady = 1'b0;
		n0 = numCommits;
		host_u.frameStart();
		tx(8'h94, 1'b1);
		tx(8'h10, 1'b1);
		tx(8'h61, 1'b1);
		tx(8'h62, 1'b1);
		tx(8'h63, 1'b0);
		host_u.frameStop();
		@(negedge clk);
		wrReady = 1'b1;
		repeat (8) @(negedge clk);
		check("stall size", 18'(wrSeen.size()), 18'h2);
		check("cmd entry", wrSeen.pop_front(), 18'h21061);
		check("cmd entry", wrSeen.pop_front(), 18'h21162);
		check("drained", 18'(wrValid), 18'h0);
		check("no commit", 18'(numCommits - n0), 18'h0);
	endtask : testStall

	// Conversion: channel from the pointer, polls refused until done
	task automatic testAdc;
		logic ack;
		logic [7:0] b;
		host_u.frameStart();
		tx(8'h94, 1'b1);
		tx(8'h58, 1'b1);
		repeat (6) @(negedge clk);
		check("channel", 18'(adcChannel), 18'hB);
		host_u.frameStart();
		tx(8'h95, 1'b0);
		ack = 1'b0;
		for (int i = 0; i < 8 && ack !== 1'b1; i++)
		begin
			host_u.frameStart();
			host_u.sendByte(8'h95, ack);
		end
		check("poll acked", 18'(ack), 18'h1);
		host_u.readByte(1'b0, b);
		check("adc read", 18'(b), 18'hF2);
		host_u.frameStop();
	endtask : testAdc

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		srst = 1'b1;
		num_errors = 0;
		compares = 0;
		numCommits = 0;
		strapPin = 1'b1;
		altTypeSel = 1'b0;
		busAddrCfg = 2'h2;
		ba2FromStrap = 1'b1;
		wrReady = 1'b1;
		repeat (16) @(negedge clk);
		srst = 1'b0;
		repeat (10) @(negedge clk);
		check("trim", 18'(trimOn), 18'h1);
		testAddress();
		testWrite();
		testRead();
		testStall();
		testAdc();
		end_sim();
	end

	// Hang guard: the tests need roughly a third of this
	initial
	begin
		#200000;
		num_errors++;
		end_sim();
	end
endmodule : i2cs_config_port_tb_top

bind i2cs_config_port i2cs_config_port_checker
	#(.ADC_CONV_CYC(ADC_CONV_CYC)) chk_u (.clk(clk), .srst(srst),
	.sclIn(sclIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .wrValid(wrValid),
	.wrReady(wrReady), .wrTarget(wrTarget), .wrAddr(wrAddr),
	.wrData(wrData), .commitStart(commitStart),
	.commitTarget(commitTarget), .adcStart(adcStart),
	.monitorSuspend(monitorSuspend),
	.active_output_trim(active_output_trim));
